// ---- i2cs_slave.sv ----
// Two-wire serial bus slave with 7/10-bit own address and a small register port.
// Assumes open-drain pads outside, and a synchronous register master on clk_sys_in.
//
// Overview of operation
// - Completed received byte moves to holding buffer with an event pulse.
// - Software writes the transmit register directly, with no second stage.
// - Status low six bits are read-only, upper bits and control are read/write.
// - Own-address register holds ten bits.
// - When enabled, wait for start, shift eight bits, then compare address.
// - Seven-bit mode compares address 6..0 with shift 7..1; bit 0 is direction.
// - Every incoming bit is sampled on the serial clock rising edge.
// - Address match acknowledges and pulses the event at the ninth falling edge.
// - Address match leaves holding buffer and buffer-full flag unchanged.
// - Read direction enters transmit, acknowledges, holds clock until software releases unless data is already loaded.
// - Transmit data changes on serial clock falling edges.
// - Each transmitted byte pulses the event at ninth falling edge, any acknowledge.
// - Write direction receives; free buffer and no overflow load and acknowledge.
// - Buffer still full: no acknowledge, no load, event still pulsed.
// - Overflow set with buffer empty: buffer loads, no acknowledge.
// - Ten-bit mode compares first byte with 11110 and address bits 9..8.
// - First ten-bit byte: write pulses and clears match flag; else clear, idle.
// - Second ten-bit byte matches low eight bits: pulse, set flag; else idle.
// - After repeated start in ten-bit mode a read needs only the first byte to match.
`timescale 1ns/10ps
`include "i2cs_defs.svh"

module i2cs_slave
  import i2cs_pkg::*;
#(
  parameter int BUS_ADDR_W = 3
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [BUS_ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Serial bus pads
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Slave event pulse
  output logic slave_event_irq_flag_out
);

  // ******************************************************************
  // Elaboration checks
  // ******************************************************************
  if (BUS_ADDR_W < 3) begin : g_bad_width
    $error("BUS_ADDR_W must be at least 3");
  end

  // ******************************************************************
  // Functions
  // ******************************************************************
  // Register select: address equal to a three-bit offset, upper bits zero.
  function automatic logic sel(input logic [BUS_ADDR_W-1:0] a, input logic [2:0] ofs);
    sel = (a == BUS_ADDR_W'(ofs));
  endfunction : sel
  // Transmit bit for the current bit count, most significant first.
  function automatic logic tx_bit(input logic [7:0] d, input logic [3:0] cnt);
    tx_bit = d[3'(3'd7 - cnt[2:0])];
  endfunction : tx_bit

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic scl_meta_reg, scl_sync_reg, scl_dly_reg;
  logic sda_meta_reg, sda_sync_reg, sda_dly_reg;
  i2cs_state_e state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_shift_reg, rx_holding_buffer, tx_shift_load_reg;
  logic [9:0] own_slave_address;
  logic [15:0] control_reg, control_next;
  logic [8:0] stat_hi_reg;
  logic rx_buffer_full_flag, tx_full_reg, rx_overflow_flag;
  logic ten_bit_match_flag, dir_reg, data_phase_reg, master_nack_reg;
  logic ack_reg, sda_low_reg, sda_low_next, scl_low_reg, irq_reg;
  // All checks run on the system clock and rest while reset is applied.
  default clocking cb_sys @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  // ******************************************************************
  // Pad synchronisers and bus events
  // ******************************************************************
  // Two flops per pad; the third stage only feeds edge detection.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_dly_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_dly_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_dly_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_dly_reg <= sda_sync_reg;
    end
  end
  // Start and stop are data edges while the clock stays high.
  wire enabled = control_reg[`I2CS_CTRL_EN];
  wire ten_mode = control_reg[`I2CS_CTRL_A10];
  wire scl_rise = scl_sync_reg & ~scl_dly_reg;
  wire scl_fall = ~scl_sync_reg & scl_dly_reg;
  wire bus_start = enabled & scl_sync_reg & scl_dly_reg & sda_dly_reg & ~sda_sync_reg;
  wire bus_stop = enabled & scl_sync_reg & scl_dly_reg & ~sda_dly_reg & sda_sync_reg;
  wire active = enabled & (state_reg != I2CS_IDLE) & ~bus_start & ~bus_stop;
  wire byte_done = active & scl_fall & (bit_cnt_reg == `I2CS_BYTE_LAST);
  wire ack_done = active & scl_fall & (bit_cnt_reg == `I2CS_ACK_BIT);

  // ******************************************************************
  // Address comparison
  // ******************************************************************
  // Seven-bit compare
  wire match7 = ~ten_mode & (rx_shift_reg[7:1] == own_slave_address[6:0]);
  wire match10_hi = ten_mode & (rx_shift_reg[7:3] == `I2CS_TEN_HDR)
                    & (rx_shift_reg[2:1] == own_slave_address[9:8]);
  wire match10_lo = (rx_shift_reg == own_slave_address[7:0]);
  wire rw_bit = rx_shift_reg[0];
  // Read header alone re-addresses a slave already fully matched.
  wire hi_read_ok = match10_hi & rw_bit & ten_bit_match_flag;
  wire addr1_ack = match7 | (match10_hi & ~rw_bit) | hi_read_ok;
  wire enter_tx = (match7 & rw_bit) | hi_read_ok;
  wire rx_load = byte_done & (state_reg == I2CS_RX) & ~rx_buffer_full_flag;
  wire rx_ack = ~rx_buffer_full_flag & ~rx_overflow_flag;
  wire rx_ovf = byte_done & (state_reg == I2CS_RX) & rx_buffer_full_flag;
  // Acknowledge bit that goes out during the ninth clock.
  wire ack_now = (state_reg == I2CS_ADDR1) ? addr1_ack :
                 (state_reg == I2CS_ADDR2) ? match10_lo :
                 (state_reg == I2CS_RX) ? rx_ack : 1'b0;
  // Event pulse at the end of the ninth clock for every byte meant for us.
  wire event_now = ack_done & ((state_reg == I2CS_RX) | (state_reg == I2CS_TX) | ack_reg);
  // Clock held after the ninth clock while nothing is loaded.
  wire hold_evt = ack_done & ~tx_full_reg
                  & (((state_reg == I2CS_ADDR1) & ack_reg & enter_tx)
                     | ((state_reg == I2CS_TX) & ~master_nack_reg));

  // ******************************************************************
  // Register port decode
  // ******************************************************************
  wire wr_ctrl = reg_wr_in & sel(reg_addr_in, `I2CS_OFS_CTRL);
  wire wr_stat = reg_wr_in & sel(reg_addr_in, `I2CS_OFS_STAT);
  wire wr_addr = reg_wr_in & sel(reg_addr_in, `I2CS_OFS_ADDR);
  wire wr_tx = reg_wr_in & sel(reg_addr_in, `I2CS_OFS_TXREG);
  wire rd_rx = reg_rd_in & sel(reg_addr_in, `I2CS_OFS_RXBUF);
  // Low status bits come from hardware only.
  wire [`I2CS_ST_RO_W-1:0] stat_lo = {ten_bit_match_flag, 1'b0, data_phase_reg,
                                      dir_reg, tx_full_reg, rx_buffer_full_flag};
  wire [15:0] status_reg = {stat_hi_reg, rx_overflow_flag, stat_lo};
  wire [15:0] rd_mux = sel(reg_addr_in, `I2CS_OFS_CTRL) ? control_reg :
                       sel(reg_addr_in, `I2CS_OFS_STAT) ? status_reg :
                       sel(reg_addr_in, `I2CS_OFS_ADDR) ? {6'h00, own_slave_address} :
                       sel(reg_addr_in, `I2CS_OFS_RXBUF) ? {8'h00, rx_holding_buffer} :
                       sel(reg_addr_in, `I2CS_OFS_TXREG) ? {8'h00, tx_shift_load_reg} :
                       16'h0000;
  // Software write wins over the hardware clear of the release bit.
  always_comb begin
    control_next = control_reg;
    if (hold_evt) begin
      control_next[`I2CS_CTRL_REL] = 1'b0;
    end
    if (wr_ctrl) begin
      control_next = reg_wdata_in;
    end
  end
  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end
  // Control and writable status bits; ten-bit own address.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      control_reg <= `I2CS_CTRL_RST;
      stat_hi_reg <= `I2CS_STHI_RST;
      own_slave_address <= `I2CS_ADDR_RST;
    end else begin
      control_reg <= control_next;
      if (wr_stat) stat_hi_reg <= reg_wdata_in[15:7];
      if (wr_addr) own_slave_address <= reg_wdata_in[9:0];
    end
  end

  // ******************************************************************
  // Buffers and flags
  // ******************************************************************
  // Software loads the transmit register directly; set wins over clear.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_shift_load_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end else begin
      if (wr_tx) tx_shift_load_reg <= reg_wdata_in[7:0];
      tx_full_reg <= wr_tx | (tx_full_reg & ~(byte_done & (state_reg == I2CS_TX)));
    end
  end
  // Double-buffered receive; loads even with overflow set.
  // Address bytes never touch buffer or full flag.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_holding_buffer <= 8'h00;
      rx_buffer_full_flag <= 1'b0;
      rx_overflow_flag <= 1'b0;
    end else begin
      if (rx_load) rx_holding_buffer <= rx_shift_reg;
      rx_buffer_full_flag <= rx_load | (rx_buffer_full_flag & ~rd_rx);
      // Overflow noted, byte dropped; set wins over software clear.
      rx_overflow_flag <= rx_ovf | (wr_stat ? reg_wdata_in[`I2CS_ST_OV] : rx_overflow_flag);
    end
  end

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  // Idle until start, then an address byte; stop returns to idle.
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    if (!enabled || bus_stop) begin
      state_next = I2CS_IDLE;
      bit_cnt_next = 4'h0;
    end else if (bus_start) begin
      state_next = I2CS_ADDR1;
      bit_cnt_next = 4'h0;
    end else if (active && scl_rise && bit_cnt_reg != `I2CS_ACK_BIT) begin
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end else if (ack_done) begin
      bit_cnt_next = 4'h0;
      case (state_reg)
        // No acknowledge goes idle; read to transmit, ten-bit write to the low byte, else receive.
        I2CS_ADDR1: begin
          if (!ack_reg) state_next = I2CS_IDLE;
          else if (enter_tx) state_next = I2CS_TX;
          else if (ten_mode) state_next = I2CS_ADDR2;
          else state_next = I2CS_RX;
        end
        // Low byte decides the full ten-bit match.
        I2CS_ADDR2: state_next = ack_reg ? I2CS_RX : I2CS_IDLE;
        I2CS_TX: state_next = master_nack_reg ? I2CS_IDLE : I2CS_TX;
        I2CS_RX: state_next = I2CS_RX;
        default: state_next = I2CS_IDLE;
      endcase
    end
  end
  // Sequencer state and bit counter.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= I2CS_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // Bits shift in on the clock rising edge; ninth bit is master acknowledge.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_shift_reg <= 8'h00;
      master_nack_reg <= 1'b0;
    end else if (active && scl_rise) begin
      if (bit_cnt_reg < `I2CS_BYTE_LAST) rx_shift_reg <= {rx_shift_reg[6:0], sda_sync_reg};
      else if (bit_cnt_reg == `I2CS_BYTE_LAST) master_nack_reg <= sda_sync_reg;
    end
  end
  // Match flag, direction and phase status; /ten-bit flag.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
      ten_bit_match_flag <= 1'b0;
      dir_reg <= 1'b0;
      data_phase_reg <= 1'b0;
    end else begin
      if (byte_done) ack_reg <= ack_now;
      if (!enabled || bus_stop) begin
        ten_bit_match_flag <= 1'b0;
        data_phase_reg <= 1'b0;
      end else if (byte_done && state_reg == I2CS_ADDR1) begin
        dir_reg <= rw_bit;
        data_phase_reg <= 1'b0;
        if (!hi_read_ok) ten_bit_match_flag <= 1'b0;
      end else if (byte_done && state_reg == I2CS_ADDR2) begin
        ten_bit_match_flag <= match10_lo;
      end else if (byte_done) begin
        data_phase_reg <= 1'b1;
      end
    end
  end

  // ******************************************************************
  // Pad drive
  // ******************************************************************
  // Transmit data change only on falling edges or while the clock is held low.
  always_comb begin
    sda_low_next = sda_low_reg;
    if (!enabled || bus_start || bus_stop) begin
      sda_low_next = 1'b0;
    end else if (active && scl_fall) begin
      if (bit_cnt_reg < `I2CS_BYTE_LAST) begin
        sda_low_next = (state_reg == I2CS_TX) & ~tx_bit(tx_shift_load_reg, bit_cnt_reg);
      end else if (bit_cnt_reg == `I2CS_BYTE_LAST) begin
        // Acknowledge driven through the ninth clock.
        sda_low_next = ack_now;
      end else begin
        sda_low_next = 1'b0;
      end
    end else if (state_reg == I2CS_TX && bit_cnt_reg == 4'h0 && !scl_sync_reg) begin
      sda_low_next = ~tx_shift_load_reg[7];
    end
  end

  // Clock held low in transmit until software sets the release bit.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      sda_low_reg <= sda_low_next;
      scl_low_reg <= enabled & (state_reg == I2CS_TX) & ~control_reg[`I2CS_CTRL_REL];
      // Event pulse at the end of every ninth clock that concerns us.
      irq_reg <= event_now;
    end
  end
  // Open-drain pads: only ever pull low, enable is active low.
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n_out = ~sda_low_reg;
  assign scl_oe_n_out = ~scl_low_reg;
  assign slave_event_irq_flag_out = irq_reg;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  property p_rx_load;
    rx_load |=> rx_buffer_full_flag && rx_holding_buffer == $past(rx_shift_reg);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("received byte not buffered");
  property p_ro_bits;
    wr_stat && !rx_load && !rd_rx |=> rx_buffer_full_flag == $past(rx_buffer_full_flag);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("status low bit written");
  property p_addr_ack;
    byte_done && state_reg == I2CS_ADDR1 && match7 |=> ##1 sda_low_reg [*1];
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address match not acknowledged");
  property p_addr_keep;
    byte_done && state_reg != I2CS_RX && !rd_rx |=> $stable(rx_buffer_full_flag);
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("address byte touched buffer");
  property p_tx_hold;
    hold_evt && !wr_ctrl |-> ##2 scl_low_reg;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("clock not held in transmit");
  property p_tx_event;
    ack_done && state_reg == I2CS_TX |=> slave_event_irq_flag_out ##1 !slave_event_irq_flag_out;
  endproperty
  a_tx_event: assert property (p_tx_event) else $error("transmit event pulse missing");
  property p_rx_full;
    rx_ovf |=> !sda_low_reg && rx_overflow_flag && $stable(rx_holding_buffer);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("full buffer overwritten or acked");
  property p_ovf_load;
    rx_load && rx_overflow_flag |=> rx_buffer_full_flag && !sda_low_reg;
  endproperty
  a_ovf_load: assert property (p_ovf_load) else $error("overflow byte acked");
  property p_ten_lo;
    ack_done && state_reg == I2CS_ADDR2 && ack_reg |=> ten_bit_match_flag && state_reg == I2CS_RX;
  endproperty
  a_ten_lo: assert property (p_ten_lo) else $error("ten-bit match not recorded");
  property p_stop;
    bus_stop |=> state_reg == I2CS_IDLE ##1 !sda_low_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not reach idle");

endmodule : i2cs_slave

// ---- i2cs_defs.svh ----
// Register offsets, field positions, reset values and fixed codes of the two-wire slave.
// Assumes a word-wide register port with one register per address.
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

// ******************************************************************
// Register offsets
// ******************************************************************
`define I2CS_OFS_CTRL 3'h0
`define I2CS_OFS_STAT 3'h1
`define I2CS_OFS_ADDR 3'h2
`define I2CS_OFS_RXBUF 3'h3
`define I2CS_OFS_TXREG 3'h4

// ******************************************************************
// Control fields
// ******************************************************************
`define I2CS_CTRL_EN 15
`define I2CS_CTRL_REL 12
`define I2CS_CTRL_A10 10
`define I2CS_CTRL_RST 16'h1000

// ******************************************************************
// Status fields
// ******************************************************************
`define I2CS_ST_RBF 0
`define I2CS_ST_TBF 1
`define I2CS_ST_RW 2
`define I2CS_ST_DATA 3
`define I2CS_ST_TEN_BIT_MATCH_FLAG 5
`define I2CS_ST_OV 6
`define I2CS_ST_RO_W 6
`define I2CS_STHI_RST 9'h000

// ******************************************************************
// Address constants
// ******************************************************************
`define I2CS_ADDR_RST 10'h000
`define I2CS_TEN_HDR 5'h1e
`define I2CS_BYTE_LAST 4'h8
`define I2CS_ACK_BIT 4'h9

`endif

// ---- i2cs_pkg.sv ----
// Types shared by the two-wire slave.
// Assumes nothing of its surroundings.
package i2cs_pkg;

  // ******************************************************************
  // Slave sequencer states
  // ******************************************************************
  typedef enum logic [2:0] {
    I2CS_IDLE = 3'b000,
    I2CS_ADDR1 = 3'b001,
    I2CS_ADDR2 = 3'b010,
    I2CS_RX = 3'b011,
    I2CS_TX = 3'b100
  } i2cs_state_e;

endpackage : i2cs_pkg

// ---- i2cs_master_model.sv ----
// Behavioural bus master that drives the two-wire slave in the bench.
// Assumes pull-ups outside, so a released line reads high.
`timescale 1ns/10ps

module i2cs_master_model (
  // Resolved lines
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  // Pulls, high drags the line low
  output logic scl_low_out,
  output logic sda_low_out
);
  // ************************************
  // Bus conditions and bits
  // ************************************

  // Both lines start released.
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // Wait out stretching, bounded so a stuck hold cannot hang the run.
  task automatic rise_scl;
    scl_low_out = 1'b0;
    for (int n = 0; n < 9000 && scl_line_in !== 1'b1; n++) #8;
  endtask : rise_scl

  task automatic start;
    #20 sda_low_out = 1'b0;
    #40 rise_scl();
    #20 sda_low_out = 1'b1;
    #20 scl_low_out = 1'b1;
  endtask : start

  // Stop condition.
  task automatic stop;
    #20 sda_low_out = 1'b1;
    #20 rise_scl();
    #20 sda_low_out = 1'b0;
    #20;
  endtask : stop

  // Nine bits MSB first; a one releases SDA, each bit is sampled while SCL is high.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_low_out = ~tx[i];
      #20 rise_scl();
      #20 rx[i] = sda_line_in;
      #20 scl_low_out = 1'b1;
    end
  endtask : xfer
endmodule : i2cs_master_model

// ---- i2cs_slave_tb.sv ----
// Self-checking bench for the two-wire slave: register port and slave transfers.
// Assumes the master model is the only other party on the pulled-up lines.
`timescale 1ns/10ps
`include "i2cs_defs.svh"

module i2cs_slave_tb;
  localparam logic [2:0] OC = `I2CS_OFS_CTRL;
  localparam logic [2:0] OS = `I2CS_OFS_STAT;
  localparam logic [2:0] OA = `I2CS_OFS_ADDR;
  localparam logic [2:0] ORX = `I2CS_OFS_RXBUF;
  localparam logic [2:0] OTX = `I2CS_OFS_TXREG;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic scl_oe_n_out;
  logic sda_oe_n_out;
  logic scl_drv;
  logic sda_drv;
  logic irq_flag;
  logic scl_low;
  logic sda_low;
  int failures = 0;
  int n_compared = 0;
  int n_irq = 0;
  int exp_irq = 0;
  // ************************************
  // Wiring, clock and event count
  // ************************************
  // Wired-AND with pull-ups: an enabled pad drives its value, whoever pulls low wins.
  wire logic scl_line = (scl_oe_n_out | scl_drv) & ~scl_low;
  wire logic sda_line = (sda_oe_n_out | sda_drv) & ~sda_low;
  i2cs_slave u_i2cs_slave (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .scl_in(scl_line), .scl_out(scl_drv),
    .scl_oe_n_out(scl_oe_n_out), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_n_out(sda_oe_n_out), .slave_event_irq_flag_out(irq_flag));
  i2cs_master_model u_i2cs_master_model (.scl_line_in(scl_line), .sda_line_in(sda_line),
    .scl_low_out(scl_low), .sda_low_out(sda_low));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  // Event pulses are one cycle wide, so count them as they pass.
  always @(posedge clk_sys_in) if (irq_flag === 1'b1) n_irq++;
  // ************************************
  // Shared tasks
  // ************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    #1; // Step off the edge so the bus model never moves on a clock edge.
  endtask : wr
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out & m, e);
  endtask : rd
  // The pulse trails the ninth fall by a few cycles; 60 ns covers it.
  task automatic byte_chk(input logic [8:0] tx, input logic [8:0] e, input int irqs);
    logic [8:0] rx;
    u_i2cs_master_model.xfer(tx, rx);
    #60;
    exp_irq += irqs;
    check({7'h00, rx}, {7'h00, e});
    check(n_irq[15:0], exp_irq[15:0]);
  endtask : byte_chk
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_regs;
    rd(OC, 16'hffff, `I2CS_CTRL_RST);
    wr(OS, 16'hffff);
    rd(OS, 16'hffff, 16'hffc0);
    wr(OS, 16'h0000);
    wr(OA, 16'hffff);
    rd(OA, 16'hffff, 16'h03ff);
    rd(3'h7, 16'hffff, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_rx7;
    wr(OC, 16'h9000);
    wr(OA, 16'h0052);
    u_i2cs_master_model.start();
    byte_chk(9'h149, 9'h148, 1);
    byte_chk(9'h14b, 9'h14a, 1);
    byte_chk(9'h079, 9'h079, 1);
    rd(ORX, 16'hffff, 16'h00a5);
    rd(OS, 16'h0041, 16'h0040);
    byte_chk(9'h0b5, 9'h0b5, 1);
    u_i2cs_master_model.start();
    byte_chk(9'h149, 9'h148, 1);
    rd(OS, 16'h0001, 16'h0001);
    rd(ORX, 16'hffff, 16'h005a);
    wr(OS, 16'h0000);
    u_i2cs_master_model.stop();
    u_i2cs_master_model.start();
    byte_chk(9'h14d, 9'h14d, 0);
    u_i2cs_master_model.stop();
    $display("test seven-bit receive done");
  endtask : t_rx7
  task automatic t_tx7;
    u_i2cs_master_model.start();
    byte_chk(9'h14b, 9'h14a, 1);
    #400 check({15'h0000, scl_oe_n_out}, 16'h0000);
    wr(OTX, 16'h00c3);
    wr(OC, 16'h9000);
    byte_chk(9'h1ff, 9'h187, 1);
    u_i2cs_master_model.stop();
    $display("test seven-bit transmit done");
  endtask : t_tx7
  task automatic t_ten;
    wr(OC, 16'h9400);
    wr(OA, 16'h02b7);
    u_i2cs_master_model.start();
    byte_chk(9'h1e9, 9'h1e8, 1);
    byte_chk(9'h16f, 9'h16e, 1);
    rd(OS, 16'h0020, 16'h0020);
    u_i2cs_master_model.start();
    byte_chk(9'h1eb, 9'h1ea, 1);
    wr(OTX, 16'h005e);
    wr(OC, 16'h9400);
    byte_chk(9'h1ff, 9'h0bd, 1);
    u_i2cs_master_model.stop();
    u_i2cs_master_model.start();
    byte_chk(9'h1eb, 9'h1eb, 0);
    u_i2cs_master_model.start();
    byte_chk(9'h1ed, 9'h1ed, 0);
    u_i2cs_master_model.start();
    byte_chk(9'h1e9, 9'h1e8, 1);
    byte_chk(9'h16d, 9'h16d, 0);
    u_i2cs_master_model.stop();
    $display("test ten-bit done");
  endtask : t_ten
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_rx7();
    t_tx7();
    t_ten();
    results();
  end
  // The tests need some 15 us; over twenty-five times that means a hang.
  initial begin
    #400000;
    failures++;
    results();
  end
endmodule : i2cs_slave_tb
